// >>> shared/crc_defines.vh
/*
 * Constants of the programmable CRC generator: register offsets,
 * field positions, FIFO depths and width thresholds.
 * Assumes inclusion by every design file of the block, once each.
 */
// Overview of operation
// - Polynomials of any order up to 32, described by 31 programmable bits.
// - Control2 bits [4:0] set polynomial order as field plus one.
// - Each set polynomial term bit enables XOR feedback at that engine bit.
// - Constant term always applied; top term implicit; term bits cover 31:1.
// - Control2 bits [12:8] set datum width as field plus one, 1 to 32.
// - FIFO depth 4 above 15, 8 for 8 to 15, 16 below 8.
// - Data written as whole bytes; bits above datum width ignored.
// - Count, control1 [12:8], rises when the datum's MSb byte is written.
// - Shifting begins only with go bit [4] set and count above zero.
// - Word moves FIFO to shift buffer, count decrements; repeat until zero.
// - Engine shifts two bits per cycle; a 32-bit word takes 16 cycles.
// - Full flag, control1 bit [7], set when count reaches depth.
// - Empty flag, control1 bit [6], set when count is zero.
// - Module enable low empties FIFO and forces count to zero.
// - Bit [3] selects MSb first when clear, LSb first when set.
// - Event on count one-to-zero, or on hardware go clear, by select bit.
// - After count event, engine still needs shift cycles to finish.
`ifndef CRC_DEFINES_VH
`define CRC_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL1      8'h00
`define OFS_CTRL2      8'h04
`define OFS_POLY_LO    8'h08
`define OFS_POLY_HI    8'h0C
`define OFS_DATA_LO    8'h10
`define OFS_DATA_HI    8'h14
`define OFS_RESULT_LO  8'h18
`define OFS_RESULT_HI  8'h1C

// ----------------------------------------------------------------
// Control1 fields
// ----------------------------------------------------------------
`define C1_EN          15
`define C1_CNT_HI      12
`define C1_CNT_LO      8
`define C1_FULL        7
`define C1_EMPTY       6
`define C1_ISEL        5
`define C1_GO          4
`define C1_LSB         3

// ----------------------------------------------------------------
// Control2 fields
// ----------------------------------------------------------------
`define C2_DW_HI       12
`define C2_DW_LO       8
`define C2_PL_HI       4
`define C2_PL_LO       0

// ----------------------------------------------------------------
// Depths and thresholds
// ----------------------------------------------------------------
`define DEPTH_WIDE     5'h04
`define DEPTH_MID      5'h08
`define DEPTH_NARROW   5'h10
`define DW_MID_MIN     5'h08
`define DW_WIDE_MIN    5'h10
`define BITS_PER_CYC   6'h02

`endif

// >>> rtl/crc_fifo.v
/*
 * Data FIFO of the CRC generator: flip-flop storage, a word count
 * and a run-time depth limit.
 * Assumes push and pop come from logic on the same clock.
 */
`include "crc_defines.vh"

module crc_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             flush,
    input  wire             push,
    input  wire [WIDTH-1:0] push_data,
    input  wire             pop,
    input  wire [4:0]       limit,
    output reg  [4:0]       count_r,
    output wire [WIDTH-1:0] head,
    output wire             full,
    output wire             empty
);
    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr_r;
    reg  [AW-1:0]    rd_ptr_r;
    wire             do_push;
    wire             do_pop;

    assign full    = (count_r >= limit);
    assign empty   = (count_r == 5'h00);
    assign do_push = push & ~full;
    assign do_pop  = pop & ~empty;
    assign head    = mem[rd_ptr_r];

    always @(posedge clk)
    begin
        if (do_push)
            mem[wr_ptr_r] <= push_data;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= 5'h00;
        end
        else if (flush)
        begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= 5'h00;
        end
        else
        begin
            if (do_push)
                wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            if (do_pop)
                rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
            if (do_push && !do_pop)
                count_r <= count_r + 5'h01;
            else if (do_pop && !do_push)
                count_r <= count_r - 5'h01;
        end
    end
endmodule

// >>> rtl/programmable_crc_generator.v
/*
 * Programmable CRC generator with APB register access, a variable
 * depth data FIFO, a shift buffer and a two-bit-per-cycle engine.
 * Assumes an APB master on pclk; only data writes are byte-lane qualified.
 */
// Decided for this implementation: the register offsets and the APB register port.
`include "crc_defines.vh"

module programmable_crc_generator (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata_r,
    output reg         pready_r,
    output reg         pslverr_r,
    output reg         crc_event_r
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [31:0] poly_terms_r;
    reg  [31:0] crc_r;
    reg  [31:0] hold_r;
    reg  [31:0] shreg_r;
    reg  [5:0]  bits_r;
    reg  [4:0]  datum_width_field_r;
    reg  [4:0]  poly_length_field_r;
    reg         module_enable_bit_r;
    reg         interrupt_select_bit_r;
    reg         shift_go_bit_r;
    reg         lsb_first_select_r;

    wire [4:0]  valid_word_count;
    wire [31:0] fifo_head;
    wire        fifo_full_flag;
    wire        fifo_empty_flag;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire        setup   = psel & ~penable;
    wire        wr_acc  = psel & penable & pready_r & pwrite;
    wire        mapped  = (paddr[1:0] == 2'b00) && (paddr <= `OFS_RESULT_HI);
    wire        wr_c1   = wr_acc && paddr == `OFS_CTRL1;
    wire        wr_c2   = wr_acc && paddr == `OFS_CTRL2;
    wire        wr_plo  = wr_acc && paddr == `OFS_POLY_LO;
    wire        wr_phi  = wr_acc && paddr == `OFS_POLY_HI;
    wire        wr_dlo  = wr_acc && paddr == `OFS_DATA_LO;
    wire        wr_dhi  = wr_acc && paddr == `OFS_DATA_HI;
    wire        wr_rlo  = wr_acc && paddr == `OFS_RESULT_LO;
    wire        wr_rhi  = wr_acc && paddr == `OFS_RESULT_HI;

    // ------------------------------------------------------------
    // Data capture into the FIFO
    // ------------------------------------------------------------
    reg  [31:0] hold_nxt;
    reg         push;
    wire [1:0]  msb_byte = datum_width_field_r[4:3];
    wire [31:0] width_mask = 32'hFFFFFFFF >> (5'h1F - datum_width_field_r);

    always @*
    begin
        hold_nxt = hold_r;
        push     = 1'b0;
        if (wr_dlo)
        begin
            if (pstrb[0])
                hold_nxt[7:0] = pwdata[7:0];
            if (pstrb[1])
                hold_nxt[15:8] = pwdata[15:8];
            push = (msb_byte == 2'h0 && pstrb[0]) ||
                   (msb_byte == 2'h1 && pstrb[1]);
        end
        if (wr_dhi)
        begin
            if (pstrb[0])
                hold_nxt[23:16] = pwdata[7:0];
            if (pstrb[1])
                hold_nxt[31:24] = pwdata[15:8];
            push = (msb_byte == 2'h2 && pstrb[0]) ||
                   (msb_byte == 2'h3 && pstrb[1]);
        end
    end

    wire [4:0]  depth_limit =
        (datum_width_field_r >= `DW_WIDE_MIN) ? `DEPTH_WIDE :
        (datum_width_field_r >= `DW_MID_MIN)  ? `DEPTH_MID  :
                                                `DEPTH_NARROW;

    wire        load = shift_go_bit_r & ~fifo_empty_flag &
                       (bits_r == 6'h00) & module_enable_bit_r;

    crc_fifo #(
        .WIDTH (32),
        .DEPTH (16),
        .AW    (4)
    ) u_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .flush     (~module_enable_bit_r | (wr_c1 & ~pwdata[`C1_EN])),
        .push      (push & module_enable_bit_r),
        .push_data (hold_nxt & width_mask),
        .pop       (load),
        .limit     (depth_limit),
        .count_r   (valid_word_count),
        .head      (fifo_head),
        .full      (fifo_full_flag),
        .empty     (fifo_empty_flag)
    );

    // ------------------------------------------------------------
    // CRC engine
    // ------------------------------------------------------------
    // order up to 32; term bits 31:1 programmable, bit 0 fixed
    function [31:0] crc_step;
        input [31:0] crc;
        input        din;
        input [31:0] poly;
        input [4:0]  poly_length_field;
        reg   [31:0] mask;
        reg          fb;
        begin
            mask = 32'hFFFFFFFF >> (5'h1F - poly_length_field);
            fb   = crc[poly_length_field] ^ din;
            crc_step = (crc << 1) & mask;
            if (fb)
                crc_step = crc_step ^ ({poly[31:1], 1'b1} & mask);
        end
    endfunction

    // MSb first from top, LSb first from bit 0
    wire        bit_a = lsb_first_select_r ? shreg_r[0] : shreg_r[31];
    wire        bit_b = lsb_first_select_r ? shreg_r[1] : shreg_r[30];
    wire [31:0] crc_one = crc_step(crc_r, bit_a, poly_terms_r,
                                   poly_length_field_r);
    wire [31:0] crc_two = crc_step(crc_one, bit_b, poly_terms_r,
                                   poly_length_field_r);
    // two bits a cycle, one for an odd tail
    wire        two     = (bits_r >= `BITS_PER_CYC);
    wire [5:0]  bits_nxt = two ? bits_r - `BITS_PER_CYC :
                                 bits_r - 6'h01;
    wire        shifting = (bits_r != 6'h00) & module_enable_bit_r;
    wire        finish  = shifting & (bits_nxt == 6'h00) &
                          fifo_empty_flag & ~push;
    wire        hw_go_clr = finish & interrupt_select_bit_r;
    // count falls from one to zero
    // shift still running after this event
    wire        cnt_evt = load & (valid_word_count == 5'h01) & ~push;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shreg_r <= 32'h00000000;
            bits_r  <= 6'h00;
        end
        else if (!module_enable_bit_r)
        begin
            shreg_r <= 32'h00000000;
            bits_r  <= 6'h00;
        end
        else if (load)
        begin
            shreg_r <= lsb_first_select_r ? fifo_head :
                       fifo_head << (5'h1F - datum_width_field_r);
            bits_r  <= {1'b0, datum_width_field_r} + 6'h01;
        end
        else if (shifting)
        begin
            if (two)
                shreg_r <= lsb_first_select_r ? shreg_r >> 2 :
                                                shreg_r << 2;
            else
                shreg_r <= lsb_first_select_r ? shreg_r >> 1 :
                                                shreg_r << 1;
            bits_r  <= bits_nxt;
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            module_enable_bit_r    <= 1'b0;
            interrupt_select_bit_r <= 1'b0;
            shift_go_bit_r         <= 1'b0;
            lsb_first_select_r     <= 1'b0;
            datum_width_field_r    <= 5'h00;
            poly_length_field_r    <= 5'h00;
            poly_terms_r           <= 32'h00000000;
            crc_r                  <= 32'h00000000;
            hold_r                 <= 32'h00000000;
            crc_event_r            <= 1'b0;
        end
        else
        begin
            crc_event_r <= cnt_evt & ~interrupt_select_bit_r |
                           hw_go_clr;
            if (wr_c1)
            begin
                module_enable_bit_r    <= pwdata[`C1_EN];
                interrupt_select_bit_r <= pwdata[`C1_ISEL];
                lsb_first_select_r     <= pwdata[`C1_LSB];
            end
            // only a hardware clear gives the event
            // Software set wins over a same-cycle hardware clear
            if (wr_c1)
                shift_go_bit_r <= pwdata[`C1_GO];
            else if (hw_go_clr)
                shift_go_bit_r <= 1'b0;
            if (wr_c2)
            begin
                datum_width_field_r <= pwdata[`C2_DW_HI:`C2_DW_LO];
                poly_length_field_r <= pwdata[`C2_PL_HI:`C2_PL_LO];
            end
            if (wr_plo)
                poly_terms_r[15:0] <= pwdata[15:0];
            if (wr_phi)
                poly_terms_r[31:16] <= pwdata[15:0];
            hold_r <= module_enable_bit_r ? hold_nxt : 32'h00000000;
            if (!module_enable_bit_r)
                crc_r <= 32'h00000000;
            else if (wr_rlo || wr_rhi)
            begin
                if (wr_rlo)
                    crc_r[15:0] <= pwdata[15:0];
                if (wr_rhi)
                    crc_r[31:16] <= pwdata[15:0];
            end
            else if (shifting)
                crc_r <= two ? crc_two : crc_one;
        end
    end

    // ------------------------------------------------------------
    // Read path and handshake
    // ------------------------------------------------------------
    // Answer in the first access cycle; data latched at setup
    reg  [15:0] rd_val;

    always @*
    begin
        rd_val = 16'h0000;
        case (paddr)
            `OFS_CTRL1:
            begin
                rd_val[`C1_EN]    = module_enable_bit_r;
                rd_val[`C1_CNT_HI:`C1_CNT_LO] = valid_word_count;
                rd_val[`C1_FULL]  = fifo_full_flag;
                rd_val[`C1_EMPTY] = fifo_empty_flag;
                rd_val[`C1_ISEL]  = interrupt_select_bit_r;
                rd_val[`C1_GO]    = shift_go_bit_r;
                rd_val[`C1_LSB]   = lsb_first_select_r;
            end
            `OFS_CTRL2:
            begin
                rd_val[`C2_DW_HI:`C2_DW_LO] = datum_width_field_r;
                rd_val[`C2_PL_HI:`C2_PL_LO] = poly_length_field_r;
            end
            `OFS_POLY_LO:   rd_val = poly_terms_r[15:0];
            `OFS_POLY_HI:   rd_val = poly_terms_r[31:16];
            `OFS_DATA_LO:   rd_val = hold_r[15:0];
            `OFS_DATA_HI:   rd_val = hold_r[31:16];
            `OFS_RESULT_LO: rd_val = crc_r[15:0];
            `OFS_RESULT_HI: rd_val = crc_r[31:16];
            default:        rd_val = 16'h0000;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r  <= 32'h00000000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= setup;
            pslverr_r <= setup & ~mapped;
            if (setup)
                prdata_r <= {16'h0000, rd_val};
        end
    end
endmodule

// >>> tb/programmable_crc_generator_sva.sv
/*
 * Checker for the CRC generator: APB handshake, read data framing,
 * status flag consistency and the event pulse.
 * Assumes a master that holds setup and access as APB requires.
 */
module crc_apb_checker (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] pwdata,
    input logic [3:0]  pstrb,
    input logic [31:0] prdata_r,
    input logic        pready_r,
    input logic        pslverr_r,
    input logic        crc_event_r
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    ready_after_setup_a:
        assert property (psel && !penable |=> pready_r)
        else $error("no ready in first access cycle");
    ready_in_access_a:
        assert property (pready_r |-> psel && penable)
        else $error("ready outside access phase");
    ready_one_cycle_a:
        assert property (pready_r |=> !pready_r)
        else $error("ready held too long");
    err_with_ready_a:
        assert property (pslverr_r |-> pready_r)
        else $error("error without ready");
    unmapped_err_a:
        assert property (psel && !penable
            && (paddr > 8'h1C || paddr[1:0] != 2'h0) |=> pslverr_r)
        else $error("unmapped access not flagged");
    mapped_ok_a:
        assert property (psel && !penable
            && paddr <= 8'h1C && paddr[1:0] == 2'h0 |=> !pslverr_r)
        else $error("mapped access flagged");
    rdata_hold_a:
        assert property (!(psel && !penable) |=> $stable(prdata_r))
        else $error("read data changed outside setup");
    upper_zero_a:
        assert property (pready_r && !pwrite |-> prdata_r[31:16] == 16'h0)
        else $error("upper read half not zero");

    // ------------------------------------------------------------
    // Status and event
    // ------------------------------------------------------------
    empty_flag_a:
        assert property (pready_r && !pwrite && paddr == 8'h00
            |-> prdata_r[6] == (prdata_r[12:8] == 5'h00))
        else $error("empty flag disagrees with count");
    full_flag_a:
        assert property (pready_r && !pwrite && paddr == 8'h00
            && prdata_r[7] |-> prdata_r[12:8] >= 5'h04)
        else $error("full flag below smallest depth");
    disabled_flush_a:
        assert property (pready_r && !pwrite && paddr == 8'h00
            && !prdata_r[15] |-> prdata_r[12:8] == 5'h00)
        else $error("count kept while disabled");
    event_pulse_a:
        assert property (crc_event_r |=> !crc_event_r)
        else $error("event longer than one cycle");
endmodule

bind programmable_crc_generator crc_apb_checker chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
    .crc_event_r(crc_event_r)
);

// >>> tb/programmable_crc_generator_bench.sv
/*
 * Self-checking bench for the CRC generator, driven over APB.
 * Assumes the block answers each transfer and bounds every wait.
 */
module programmable_crc_generator_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    wire  [31:0] prdata_r;
    wire         pready_r;
    wire         pslverr_r;
    wire         crc_event_r;
    int          err_count = 0;
    int          n_checks = 0;
    int          cyc;
    logic [31:0] rdv;
    logic        rerr;
    logic [31:0] ctl;
    logic [31:0] exp_crc;
    // Depth table: width field, depth, closing address and lane
    logic [4:0]  dwk [3] = '{5'h07, 5'h0F, 5'h1F};
    int          dp [3] = '{16, 8, 4};
    logic [7:0]  da [3] = '{8'h10, 8'h10, 8'h14};
    logic [3:0]  ds [3] = '{4'h1, 4'h2, 4'h2};
    // Engine cases; bit 0 of terms varies since it must not matter
    logic [4:0]  tp [4] = '{5'h0F, 5'h0F, 5'h1F, 5'h07};
    logic [4:0]  tw [4] = '{5'h0F, 5'h0F, 5'h1F, 5'h06};
    logic [31:0] tt [4] = '{32'h1020, 32'h1021, 32'h04C11DB6, 32'h06};
    logic [31:0] tv [4] = '{32'hFFFF, 32'h1D0F, 32'hFFFFFFFF, 32'h0};
    logic [31:0] td [4] = '{32'h1234, 32'hA5C3, 32'hCAFE0001, 32'hE5};
    logic        ti [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    logic        tl [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

    programmable_crc_generator DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
        .crc_event_r(crc_event_r)
    );

    always #50 pclk = ~pclk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One transfer; request held until ready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog bounds this wait
        do
            @(posedge pclk);
        while (pready_r !== 1'b1);
        rd = prdata_r;
        er = pslverr_r;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        logic [31:0] x;
        logic        e;
        apb(1'b1, a, d, s, x, e);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        logic        e;
        apb(1'b0, a, 32'h0, 4'h0, x, e);
        chk(x, exp);
    endtask

    // Reference remainder, fed bit by bit as the engine would
    function automatic logic [31:0] crc_ref(
        logic [31:0] c, logic [31:0] t, logic [31:0] d,
        logic [4:0] pl, logic [4:0] dw, logic lsb);
        logic [31:0] m;
        logic        fb;
        m = 32'hFFFFFFFF >> (31 - pl);
        c = c & m;
        for (int i = 0; i <= dw; i++)
        begin
            fb = c[pl] ^ (lsb ? d[i] : d[dw - i]);
            c = (c << 1) & m;
            if (fb)
                c = c ^ ({t[31:1], 1'b1} & m);
        end
        return c;
    endfunction

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Whole run is a few hundred cycles; this leaves ample margin
    initial
    begin
        repeat (20000) @(posedge pclk);
        err_count++;
        report_and_stop();
    end

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(8'h00, 32'h40);
        rdc(8'h04, 32'h0);
        apb(1'b0, 8'h20, 32'h0, 4'h0, rdv, rerr);
        chk(rerr, 1'b1);
        apb(1'b0, 8'h02, 32'h0, 4'h0, rdv, rerr);
        chk(rerr, 1'b1);
        $display("test reset and map done");
        for (int k = 0; k < 3; k++)
        begin
            wr(8'h00, 32'h8000, 4'h3);
            wr(8'h04, {19'h0, dwk[k], 8'h00}, 4'h3);
            // One extra write past depth must be dropped
            for (int j = 0; j <= dp[k]; j++)
                wr(da[k], 32'h5A5A5A5A, ds[k]);
            rdc(8'h00, 32'h8080 | (dp[k] << 8));
            wr(8'h00, 32'h0, 4'h3);
            rdc(8'h00, 32'h40);
            $display("test depth %0d done", dp[k]);
        end
        for (int k = 0; k < 4; k++)
        begin
            ctl = {16'h0, 1'b1, 9'h0, ti[k], 1'b0, tl[k], 3'h0};
            wr(8'h00, 32'h0, 4'h3);
            wr(8'h00, ctl, 4'h3);
            wr(8'h04, {19'h0, tw[k], 3'h0, tp[k]}, 4'h3);
            wr(8'h08, tt[k], 4'h3);
            wr(8'h0C, tt[k] >> 16, 4'h3);
            wr(8'h18, tv[k], 4'h3);
            wr(8'h1C, tv[k] >> 16, 4'h3);
            wr(8'h10, td[k], 4'h3);
            if (tw[k] > 5'h0F)
                wr(8'h14, td[k] >> 16, 4'h3);
            exp_crc = crc_ref(tv[k], tt[k], td[k], tp[k], tw[k], tl[k]);
            rdc(8'h00, ctl | 32'h100);
            wr(8'h00, ctl | 32'h10, 4'h3);
            cyc = 0;
            do
            begin
                @(posedge pclk);
                cyc++;
            end
            while (crc_event_r !== 1'b1 && cyc < 200);
            chk(cyc < 200, 1'b1);
            if (tw[k] == 5'h1F)
                chk(cyc >= 17 && cyc <= 22, 1'b1);
            if (!ti[k])
                repeat ((tp[k] + 1) / 2 + 2) @(posedge pclk);
            rdc(8'h18, exp_crc & 32'hFFFF);
            rdc(8'h1C, exp_crc >> 16);
            rdc(8'h00, ctl | (ti[k] ? 32'h40 : 32'h50));
            $display("test engine case %0d done", k);
        end
        report_and_stop();
    end
endmodule
